// ---- shared/ebr_map.svh ----
// register offsets, field positions and reset values for the refresh/bus control block
`ifndef EBR_MAP_SVH
`define EBR_MAP_SVH
`define EBR_OFF_PERIOD 16'hfed9
`define EBR_OFF_CTRL 16'hfed8
`define EBR_OFF_COUNT 16'hfeda
`define EBR_OFF_STATUS 16'hfedc
`define EBR_BIT_IDLE 0
`define EBR_BIT_BREL 1
`define EBR_BIT_PRE2 2
`define EBR_BIT_RFEN 3
`define EBR_RST_CTRL 4'h0
`define EBR_RST_PERIOD 8'hff
`define EBR_RST_COUNT 8'h00
// the offsets above are word indexes; the register bus sees the low 16 bits of four times the index
`define EBR_BYTE_ADDR(idx) (16'((idx) << 2))
`endif

// ---- shared/ebr_pkg.sv ----
// types shared by the refresh/bus control block
package ebr_pkg;
	typedef struct packed {
		logic refresh_en;
		logic pre_two;
		logic brel_en;
		logic idle_en;
	} ebr_ctrl_t;
	typedef struct packed {
		logic valid;
		logic read;
		logic [2:0] area;
	} ebr_cyc_t;
	typedef enum logic [2:0] {ST_IDLE, ST_ACCESS, ST_GAP, ST_PRE, ST_RELEASED} ebr_state_t;
endpackage

// ---- verilog/ebr_ctrl.sv ----
// external bus controller: idle insert, bus release, precharge and refresh timer
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "ebr_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RL1 - with idle insert set, one idle cycle separates back-to-back external reads to different areas.
// RL2 - the external bus is granted to an outside master only while bus release is enabled.
// RL3 - a dram precharge lasts one state with the length bit at 0 and two states at 1.
// RL4 - refresh activity happens only while refresh enable is set.
// RL5 - the refresh timer counter advances each clock and software reads and writes it as 8 bits.
// RL6 - the 8-bit refresh period constant sets the count at which a compare match occurs.
// RL7 - on a match with refresh enabled a refresh request is raised and the counter restarts at 0.
module ebr_ctrl
	import ebr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire ebr_cyc_t cyc_req,
	input wire logic dram_cyc,
	output logic cyc_start,
	output logic idle_cyc,
	output logic precharge,
	input wire logic ext_breq,
	output logic ext_back,
	output logic refresh_req,
	input wire logic refresh_ack
);
	ebr_ctrl_t ctrl_q;
	logic [7:0] period_q, count_q;
	logic [15:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic aw_have_q, w_have_q;
	ebr_state_t state_q;
	logic [2:0] last_area_q;
	logic last_read_q, last_dram_q;
	logic pre_cnt_q;
	logic breq_s1_q, breq_s2_q;

	////////////////////////////////////////////////////////////////////////////////
	// axi write side: address and data held until both are present
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire [15:0] wa = aw_have_q ? awaddr_q : s_axi_awaddr;
	wire [31:0] wd = w_have_q ? wdata_q : s_axi_wdata;
	wire [3:0] ws = w_have_q ? wstrb_q : s_axi_wstrb;
	wire aw_ok = aw_have_q || aw_take;
	wire w_ok = w_have_q || w_take;
	wire wr_fire = aw_ok && w_ok && !s_axi_bvalid;
	// one register to an aligned word; odd word offsets still land on aligned byte addresses
	wire wr_hit_ctrl = wa == `EBR_BYTE_ADDR(`EBR_OFF_CTRL);
	wire wr_hit_per = wa == `EBR_BYTE_ADDR(`EBR_OFF_PERIOD);
	wire wr_hit_cnt = wa == `EBR_BYTE_ADDR(`EBR_OFF_COUNT);
	wire wr_hit_stat = wa == `EBR_BYTE_ADDR(`EBR_OFF_STATUS);
	wire wr_mapped = wr_hit_ctrl || wr_hit_per || wr_hit_cnt || wr_hit_stat;
	// only lane 0 carries the 8-bit registers
	wire wr_lane0 = wr_fire && ws[0];

	always_ff @(posedge core_clk or posedge rst)
		if (rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 16'h0000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end
		else
		begin
			s_axi_awready <= !aw_ok && !s_axi_bvalid;
			s_axi_wready <= !w_ok && !s_axi_bvalid;
			if (aw_take)
				awaddr_q <= s_axi_awaddr;
			if (w_take)
			begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			aw_have_q <= aw_ok && !wr_fire;
			w_have_q <= w_ok && !wr_fire;
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? 2'b00 : 2'b10;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end

	////////////////////////////////////////////////////////////////////////////////
	// axi read side: one cycle after the address is taken
	wire ar_take = s_axi_arvalid && s_axi_arready;
	// read decode on the same word addresses as the write side
	wire rd_hit_ctrl = s_axi_araddr == `EBR_BYTE_ADDR(`EBR_OFF_CTRL);
	wire rd_hit_per = s_axi_araddr == `EBR_BYTE_ADDR(`EBR_OFF_PERIOD);
	wire rd_hit_cnt = s_axi_araddr == `EBR_BYTE_ADDR(`EBR_OFF_COUNT);
	wire rd_hit_stat = s_axi_araddr == `EBR_BYTE_ADDR(`EBR_OFF_STATUS);
	wire [31:0] rd_val = rd_hit_ctrl ? {28'h000_0000, ctrl_q} :
		rd_hit_per ? {24'h00_0000, period_q} :
		rd_hit_cnt ? {24'h00_0000, count_q} :
		rd_hit_stat ? {26'h000_0000, refresh_req, ext_back, precharge, state_q} :
		32'h0000_0000;
	wire rd_mapped = rd_hit_ctrl || rd_hit_per || rd_hit_cnt || rd_hit_stat;

	always_ff @(posedge core_clk or posedge rst)
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end
		else
		begin
			// no new address while an answer waits, so read data is never overwritten
			s_axi_arready <= !s_axi_rvalid && !ar_take;
			if (ar_take)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_mapped ? 2'b00 : 2'b10;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end

	////////////////////////////////////////////////////////////////////////////////
	// control and period registers
	always_ff @(posedge core_clk or posedge rst)
		if (rst)
		begin
			ctrl_q <= `EBR_RST_CTRL;
			period_q <= `EBR_RST_PERIOD;
		end
		else if (wr_lane0)
		begin
			if (wr_hit_ctrl)
				ctrl_q <= wd[3:0];
			if (wr_hit_per)
				period_q <= wd[7:0]; // [RL6]
		end

	////////////////////////////////////////////////////////////////////////////////
	// refresh timer: compare match restarts the count, software write wins
	wire match = ctrl_q.refresh_en && count_q == period_q; // [RL6]
	always_ff @(posedge core_clk or posedge rst)
		if (rst)
		begin
			count_q <= `EBR_RST_COUNT;
			refresh_req <= 1'b0;
		end
		else
		begin
			if (wr_lane0 && wr_hit_cnt)
				count_q <= wd[7:0]; // [RL5]
			else if (!ctrl_q.refresh_en)
				count_q <= `EBR_RST_COUNT; // [RL4]
			else if (match)
				count_q <= `EBR_RST_COUNT; // [RL7]
			else
				count_q <= count_q + 8'h01; // [RL5]
			// a new match wins over the acknowledge in the same cycle
			if (match)
				refresh_req <= 1'b1; // [RL7]
			else if (refresh_ack || !ctrl_q.refresh_en)
				refresh_req <= 1'b0; // [RL4]
		end

	////////////////////////////////////////////////////////////////////////////////
	// bus cycle sequencer
	wire breq_sync = breq_s2_q;
	wire need_gap = ctrl_q.idle_en && last_read_q && cyc_req.read &&
		cyc_req.area != last_area_q; // [RL1]
	wire can_release = ctrl_q.brel_en && breq_sync; // [RL2]

	always_ff @(posedge core_clk or posedge rst)
		if (rst)
		begin
			breq_s1_q <= 1'b0;
			breq_s2_q <= 1'b0;
			state_q <= ST_IDLE;
			cyc_start <= 1'b0;
			idle_cyc <= 1'b0;
			precharge <= 1'b0;
			ext_back <= 1'b0;
			last_area_q <= 3'h0;
			last_read_q <= 1'b0;
			last_dram_q <= 1'b0;
			pre_cnt_q <= 1'b0;
		end
		else
		begin
			breq_s1_q <= ext_breq;
			breq_s2_q <= breq_s1_q;
			cyc_start <= 1'b0;
			idle_cyc <= 1'b0;
			precharge <= 1'b0;
			case (state_q)
				ST_IDLE, ST_ACCESS:
					if (state_q == ST_ACCESS && last_dram_q)
					begin
						// precharge follows each dram access
						state_q <= ST_PRE;
						precharge <= 1'b1;
						pre_cnt_q <= ctrl_q.pre_two; // [RL3]
					end
					else if (can_release)
					begin
						state_q <= ST_RELEASED;
						ext_back <= 1'b1; // [RL2]
					end
					else if (cyc_req.valid && need_gap)
					begin
						state_q <= ST_GAP;
						idle_cyc <= 1'b1; // [RL1]
						last_read_q <= 1'b0;
					end
					else if (cyc_req.valid)
					begin
						state_q <= ST_ACCESS;
						cyc_start <= 1'b1;
						last_area_q <= cyc_req.area;
						last_read_q <= cyc_req.read;
						last_dram_q <= dram_cyc;
					end
					else
					begin
						state_q <= ST_IDLE;
						last_read_q <= 1'b0;
					end
				ST_GAP:
					state_q <= ST_IDLE;
				ST_PRE:
					if (pre_cnt_q)
					begin
						precharge <= 1'b1; // [RL3]
						pre_cnt_q <= 1'b0;
					end
					else
					begin
						state_q <= ST_IDLE;
						last_dram_q <= 1'b0;
					end
				ST_RELEASED:
					if (!breq_sync || !ctrl_q.brel_en)
					begin
						state_q <= ST_IDLE;
						ext_back <= 1'b0;
						last_read_q <= 1'b0;
					end
				default:
					state_q <= ST_IDLE;
			endcase
		end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	bus_release_a: assert property (@(posedge core_clk) disable iff (rst) // [RL2]
		$rose(ext_back) |-> $past(ctrl_q.brel_en))
		else $error("bus granted while release disabled");
	idle_gap_a: assert property (@(posedge core_clk) disable iff (rst) // [RL1]
		idle_cyc |-> ctrl_q.idle_en ##1 !cyc_start)
		else $error("idle cycle without idle insert");
	pre_two_a: assert property (@(posedge core_clk) disable iff (rst) // [RL3]
		$rose(precharge) && ctrl_q.pre_two |=> precharge ##1 !precharge)
		else $error("two-state precharge wrong length");
	pre_one_a: assert property (@(posedge core_clk) disable iff (rst) // [RL3]
		$rose(precharge) && !ctrl_q.pre_two |=> !precharge)
		else $error("one-state precharge wrong length");
	refresh_off_a: assert property (@(posedge core_clk) disable iff (rst) // [RL4]
		!$past(ctrl_q.refresh_en) |-> !$rose(refresh_req))
		else $error("refresh raised while disabled");
	count_step_a: assert property (@(posedge core_clk) disable iff (rst) // [RL5]
		ctrl_q.refresh_en && !match && !wr_lane0 |=> count_q == $past(count_q) + 8'h01)
		else $error("refresh counter did not advance");
	match_req_a: assert property (@(posedge core_clk) disable iff (rst) // [RL6]
		match |=> refresh_req)
		else $error("compare match without refresh request");
	match_clr_a: assert property (@(posedge core_clk) disable iff (rst) // [RL7]
		match && !wr_lane0 |=> count_q == 8'h00)
		else $error("counter not restarted after match");
endmodule

// ---- test/ebr_far_model.sv ----
// far-side model: outside bus master and dram refresh acknowledge
`timescale 1ns/1ps
module ebr_far_model
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic want_bus,
	output logic ext_breq,
	input wire logic refresh_req,
	output logic refresh_ack
);
	logic [1:0] wait_q;
	logic [1:0] wait_d;
	// outside master asks as long as it wants the bus
	assign ext_breq = want_bus;
	// dram answers three cycles late, slow on purpose, so the request must stay up
	assign wait_d = {wait_q[0], refresh_req & ~refresh_ack};
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			wait_q <= 2'h0;
			refresh_ack <= 1'b0;
		end
		else
		begin
			wait_q <= wait_d;
			refresh_ack <= wait_q[1] & refresh_req;
		end
	end
endmodule

// ---- test/ebr_ctrl_tb_top.sv ----
// self-checking bench for the refresh and bus control block
`timescale 1ns/1ps
`include "ebr_map.svh"
`define TB_CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
	$display("unexpected %s expected %h seen %h", nm, exp, got); end end
module ebr_ctrl_tb_top
	import ebr_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, dram_cyc = 0, want_bus = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [7:0] d;
	ebr_cyc_t cyc_req = '0;
	logic cyc_start, idle_cyc, precharge, ext_breq, ext_back, refresh_req, refresh_ack;
	int bad_count = 0, comparisons = 0, ticks = 0, n_ref, n_back, n_pre, n_idle;

	ebr_ctrl ebr_ctrl_i (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cyc_req, .dram_cyc, .cyc_start,
		.idle_cyc, .precharge, .ext_breq, .ext_back, .refresh_req, .refresh_ack);
	ebr_far_model ebr_far_model_i (.core_clk, .rst, .want_bus, .ext_breq, .refresh_req,
		.refresh_ack);

	////////////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial
	begin
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		ticks++;
		if (ticks == 20000)
		begin
			bad_count++;
			final_report();
		end
	end

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite master; address and data offered together, each dropped when taken
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		logic done;
		done = 1'b0;
		@(posedge core_clk);
		s_axi_awaddr <= `EBR_BYTE_ADDR(a);
		s_axi_wdata <= {24'h00_0000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done)
		begin
			@(posedge core_clk);
			done = !s_axi_awvalid && !s_axi_wvalid && s_axi_bvalid === 1'b1;
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// a is the register's word index; data and response land in d and r
	task automatic rd(input logic [15:0] a);
		@(posedge core_clk);
		s_axi_araddr <= `EBR_BYTE_ADDR(a);
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
		d = s_axi_rdata[7:0];
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rchk(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
		rd(a);
		`TB_CHK("rdata", e, d)
		`TB_CHK("rresp", er, r)
	endtask

	// count high cycles of refresh_req, ext_back and precharge, sampled once settled
	task automatic watch(input int n);
		n_ref = 0;
		n_back = 0;
		n_pre = 0;
		repeat (n)
		begin
			@(posedge core_clk);
			#1;
			n_ref += (refresh_req === 1'b1);
			n_back += (ext_back === 1'b1);
			n_pre += (precharge === 1'b1);
		end
	endtask

	// holds the request until taken; caller releases, so reads can run back to back
	task automatic cyc(input logic [2:0] ar, input logic dr);
		n_idle = 0;
		cyc_req <= '{1'b1, 1'b1, ar};
		dram_cyc <= dr;
		do
		begin
			@(posedge core_clk);
			#1;
			n_idle += (idle_cyc === 1'b1);
		end
		while (cyc_start !== 1'b1); // a missing start is caught by the hang guard
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// test sequence
	initial
	begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		rchk(`EBR_OFF_CTRL, 8'h00, 2'b00);
		rchk(`EBR_OFF_PERIOD, `EBR_RST_PERIOD, 2'b00);
		rchk(16'hfed0, 8'h00, 2'b10);
		wr(16'hfed0, 8'h5a);
		`TB_CHK("bresp", 2'b10, r)
		wr(`EBR_OFF_PERIOD, 8'h10);
		rchk(`EBR_OFF_PERIOD, 8'h10, 2'b00);
		// a write with lane 0 off is answered but changes nothing
		s_axi_wstrb <= 4'h0;
		wr(`EBR_OFF_PERIOD, 8'h77);
		s_axi_wstrb <= 4'hf;
		`TB_CHK("bresp_nostrb", 2'b00, r)
		rchk(`EBR_OFF_PERIOD, 8'h10, 2'b00);
		watch(40);
		`TB_CHK("refresh_off", 0, n_ref)
		rchk(`EBR_OFF_COUNT, 8'h00, 2'b00);
		wr(`EBR_OFF_CTRL, 8'h01 << `EBR_BIT_RFEN);
		watch(30);
		`TB_CHK("refresh_on", 1'b1, n_ref > 0)
		rd(`EBR_OFF_COUNT);
		`TB_CHK("count_resp", 2'b00, r)
		`TB_CHK("count_range", 1'b1, d <= 8'h10)
		wr(`EBR_OFF_CTRL, 8'h00);
		watch(6);
		watch(40);
		`TB_CHK("refresh_stop", 0, n_ref)
		// outside master refused, then granted, then gives back
		want_bus <= 1'b1;
		watch(10);
		`TB_CHK("back_refused", 0, n_back)
		wr(`EBR_OFF_CTRL, 8'h01 << `EBR_BIT_BREL);
		watch(10);
		`TB_CHK("back_granted", 1'b1, n_back > 0)
		rd(`EBR_OFF_STATUS);
		`TB_CHK("status_back", 1'b1, d[4])
		want_bus <= 1'b0;
		watch(6);
		watch(6);
		`TB_CHK("back_dropped", 0, n_back)
		wr(`EBR_OFF_CTRL, 8'h01 << `EBR_BIT_IDLE);
		cyc(3'h1, 1'b0);
		cyc(3'h2, 1'b0);
		`TB_CHK("idle_diff", 1, n_idle)
		cyc(3'h2, 1'b0);
		`TB_CHK("idle_same", 0, n_idle)
		cyc_req <= '0;
		wr(`EBR_OFF_CTRL, 8'h00);
		cyc(3'h4, 1'b0);
		cyc(3'h5, 1'b0);
		`TB_CHK("idle_off", 0, n_idle)
		cyc_req <= '0;
		for (int p = 0; p < 2; p++)
		begin
			wr(`EBR_OFF_CTRL, 8'(p) << `EBR_BIT_PRE2);
			cyc(3'h0, 1'b1);
			cyc_req <= '0;
			watch(8);
			`TB_CHK("precharge_len", p + 1, n_pre)
		end
		final_report();
	end
endmodule
